// *** design/adc_cfg.svh ***
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH
`define CH_N 4
`define ACC_W 20
`define RES_W 16
`define OFS_OPSTATE 4'h0
`define OFS_LOWCFG 4'h1
`define OFS_HIGHCFG 4'h2
`define OFS_STATUS 4'h3
`define OFS_RES_FIRST 4'h4
`define OFS_RES_LAST 4'hB
`define OFS_CLK_HI 4'hC
`define OFS_CLK_MID 4'hD
`define OFS_CLK_LO 4'hE
`define START_BIT 0
`define LEN_HI 3
`define LEN_LO 0
`define REF_HI 6
`define REF_LO 4
`define MODE_HI 1
`define MODE_LO 0
`define SB_BIT 2
`define TIME_MEASURE_ENABLE_BIT 3
`define LEN_BASE 5'h0A
`define LEN_MAX_CODE 4'hA
`define LEN_CUT_CODE 4'h6
`define REF_TOP 3'h4
`define RES_MAX 16'hFFFF
`endif

// *** design/adc_pkg.sv ***
`include "adc_cfg.svh"
package adc_pkg;
	typedef enum logic [1:0] {
		continuous_mode = 2'h0,
		command_mode = 2'h1,
		edge_start_mode = 2'h3,
		edge_window_mode = 2'h2
	} mode_e;
	typedef enum logic [1:0] {
		st_idle = 2'h0,
		st_run = 2'h1,
		st_done = 2'h3
	} state_e;
	typedef struct packed {
		logic rsvd;
		logic [2:0] ref_code;
		logic [3:0] len_code;
	} low_cfg_s;
	typedef struct packed {
		logic [3:0] rsvd;
		logic time_measure_enable;
		logic standby_enable;
		mode_e mode;
	} high_cfg_s;
	typedef struct packed {
		logic en;
		logic [3:0] addr;
		logic [7:0] data;
	} reg_req_s;
	typedef logic [`CH_N-1:0][`RES_W-1:0] res_arr_t;
	typedef logic [`CH_N-1:0][`ACC_W-1:0] acc_arr_t;
	typedef struct packed {
		state_e st;
		logic start;
		low_cfg_s low;
		high_cfg_s high;
		logic [`ACC_W-1:0] win;
		acc_arr_t acc;
		res_arr_t res;
		logic [`ACC_W-1:0] clk_cnt;
		logic busy;
		logic standby;
		logic [`CH_N-1:0] ch_on;
		logic [2:0] ref_lvl;
		logic [7:0] rdata;
		logic syn_m;
		logic syn_s;
		logic syn_d;
	} core_s;
endpackage

// *** design/adc_standby_and_count_config.sv ***
`timescale 1ns/1ps
`include "adc_cfg.svh"
// What this block does
// - In continuous mode a start bit of 1 leaves standby and 0 returns to it.
// - In both edge modes a measurement start clears the standby enable bit.
// - In command mode the block never enters standby.
// - Each channel sums its modulator pulses in a counter of up to 20 bits.
// - At the end of integration the counter becomes the channel result.
// - The integration length code sits in bits 3 to 0 of the low config.
// - The reference select code sits in bits 6 to 4 of the low config.
// - Length codes 0 to 10 give 1024 to 1048576 counts, doubling per step.
// - Continuous, command and edge start modes time the window internally.
// - Length codes above 6 keep only the upper 16 bits of the count.
// - Edge window mode ignores the length code and ends on a sync edge.
// - With time measurement enabled the window clock count is kept.
// - Reference codes 0 to 3 pick four levels and any 1xx the largest.
// - In continuous and command modes writing the start bit to 1 starts a conversion.
// - After an edge mode conversion standby follows the standby enable.
module adc_standby_and_count_config
	import adc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire adc_pkg::reg_req_s reg_i,
	input wire logic syn_n_i,
	input wire logic [`CH_N-1:0] mod_pulse_i,
	output logic [7:0] rd_data_o,
	output logic busy_o,
	output logic standby_o,
	output logic [`CH_N-1:0] ch_enable_o,
	output logic [2:0] ref_level_o,
	output adc_pkg::res_arr_t result_o,
	output logic [`ACC_W-1:0] clock_count_o
);
	import adc_pkg::*;

	core_s s_ff;
	core_s nxt_s;
	acc_arr_t acc_nxt;
	res_arr_t res_new;
	logic [3:0] len;
	logic [`ACC_W-1:0] win_last;
	logic sync_fall;
	logic edge_mode;
	logic conv_end;
	logic [`RES_W-1:0] rd_res;

	// Codes above the documented range are clamped to the longest window.
	assign len = (s_ff.low.len_code > `LEN_MAX_CODE) ?
		`LEN_MAX_CODE : s_ff.low.len_code;
	assign win_last = `ACC_W'((21'h1 << (`LEN_BASE + 5'(len))) - 21'h1);
	assign sync_fall = s_ff.syn_d & ~s_ff.syn_s;
	assign edge_mode = (s_ff.high.mode == edge_start_mode) ||
		(s_ff.high.mode == edge_window_mode);
	assign conv_end = (s_ff.st == st_run) &&
		((s_ff.high.mode == edge_window_mode) ? sync_fall :
		(s_ff.win == win_last));
	assign rd_res = s_ff.res[3'((reg_i.addr - `OFS_RES_FIRST) >> 1)];

	genvar c;
	generate
		for (c = 0; c < `CH_N; c++)
		begin : g_ch
			// The count saturates so a long external window cannot wrap.
			assign acc_nxt[c] = (&s_ff.acc[c]) ? s_ff.acc[c] :
				s_ff.acc[c] + `ACC_W'(mod_pulse_i[c] & s_ff.ch_on[c]);
			always_comb
			begin
				if (s_ff.high.mode == edge_window_mode)
				begin
					res_new[c] = (|acc_nxt[c][`ACC_W-1:`RES_W]) ?
						`RES_MAX : acc_nxt[c][`RES_W-1:0];
				end
				else if (len > `LEN_CUT_CODE)
				begin
					res_new[c] = `RES_W'(acc_nxt[c] >> (len - `LEN_CUT_CODE));
				end
				else
				begin
					res_new[c] = acc_nxt[c][`RES_W-1:0];
				end
			end
		end
	endgenerate

	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.syn_m = syn_n_i;
		nxt_s.syn_s = s_ff.syn_m;
		nxt_s.syn_d = s_ff.syn_s;
		unique case (s_ff.st)
			st_idle:
			begin
				if ((edge_mode && sync_fall) || (!edge_mode && s_ff.start))
				begin
					nxt_s.st = st_run;
					nxt_s.busy = 1'b1;
					nxt_s.win = '0;
					nxt_s.acc = '0;
					if (edge_mode)
					begin
						nxt_s.high.standby_enable = 1'b0;
					end
				end
			end
			st_run:
			begin
				nxt_s.win = (&s_ff.win) ? s_ff.win : s_ff.win + `ACC_W'(1);
				nxt_s.acc = acc_nxt;
				if (s_ff.high.mode == continuous_mode && !s_ff.start)
				begin
					// Clearing the start bit aborts the running window.
					// The counts freeze, though the cycle whose write raises standby still counts.
					nxt_s.acc = s_ff.acc;
					nxt_s.st = st_idle;
					nxt_s.busy = 1'b0;
				end
				else if (conv_end)
				begin
					nxt_s.st = st_done;
					nxt_s.busy = 1'b0;
					nxt_s.res = res_new;
					nxt_s.clk_cnt = s_ff.high.time_measure_enable ?
						nxt_s.win : '0;
					if (s_ff.high.mode == command_mode)
					begin
						nxt_s.start = 1'b0;
					end
				end
			end
			st_done:
			begin
				nxt_s.st = st_idle;
			end
		endcase
		// A host write lands after the hardware updates, so it wins a tie.
		if (reg_i.en)
		begin
			unique case (reg_i.addr)
				`OFS_OPSTATE:
				begin
					nxt_s.start = reg_i.data[`START_BIT];
				end
				`OFS_LOWCFG:
				begin
					nxt_s.low.len_code = reg_i.data[`LEN_HI:`LEN_LO];
					nxt_s.low.ref_code = reg_i.data[`REF_HI:`REF_LO];
				end
				`OFS_HIGHCFG:
				begin
					nxt_s.high.mode = mode_e'(reg_i.data[`MODE_HI:`MODE_LO]);
					nxt_s.high.standby_enable = reg_i.data[`SB_BIT];
					nxt_s.high.time_measure_enable = reg_i.data[`TIME_MEASURE_ENABLE_BIT];
				end
				default:
				begin
				end
			endcase
		end
		unique case (nxt_s.high.mode)
			continuous_mode: nxt_s.standby = !nxt_s.start;
			command_mode: nxt_s.standby = 1'b0;
			default: nxt_s.standby = (nxt_s.st == st_idle) &&
				nxt_s.high.standby_enable;
		endcase
		nxt_s.ch_on = {`CH_N{!nxt_s.standby}};
		nxt_s.ref_lvl = nxt_s.low.ref_code[2] ? `REF_TOP :
			{1'b0, nxt_s.low.ref_code[1:0]};
		if (reg_i.addr >= `OFS_RES_FIRST && reg_i.addr <= `OFS_RES_LAST)
		begin
			nxt_s.rdata = reg_i.addr[0] ? rd_res[7:0] : rd_res[15:8];
		end
		else
		begin
			unique case (reg_i.addr)
				`OFS_OPSTATE: nxt_s.rdata = {7'h00, s_ff.start};
				`OFS_LOWCFG: nxt_s.rdata = s_ff.low;
				`OFS_HIGHCFG: nxt_s.rdata = s_ff.high;
				`OFS_STATUS: nxt_s.rdata = {6'h00, s_ff.standby, s_ff.busy};
				`OFS_CLK_HI: nxt_s.rdata = {4'h0, s_ff.clk_cnt[19:16]};
				`OFS_CLK_MID: nxt_s.rdata = s_ff.clk_cnt[15:8];
				`OFS_CLK_LO: nxt_s.rdata = s_ff.clk_cnt[7:0];
				default: nxt_s.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			s_ff <= '0;
		end
		else
		begin
			s_ff <= nxt_s;
		end
	end

	assign rd_data_o = s_ff.rdata;
	assign busy_o = s_ff.busy;
	assign standby_o = s_ff.standby;
	assign ch_enable_o = s_ff.ch_on;
	assign ref_level_o = s_ff.ref_lvl;
	assign result_o = s_ff.res;
	assign clock_count_o = s_ff.clk_cnt;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	continuous_mode_standby_a: assert property (
		$past(rst_n_i) && (s_ff.high.mode == continuous_mode) &&
		($past(s_ff.high.mode) == continuous_mode)
		|-> (standby_o == !s_ff.start))
		else $error("continuous standby does not follow start bit");
	sb_clear_a: assert property (
		(s_ff.st == st_idle) && (nxt_s.st == st_run) && edge_mode &&
		!reg_i.en |=> !s_ff.high.standby_enable && busy_o)
		else $error("standby enable not cleared at edge start");
	cmd_standby_a: assert property (
		(nxt_s.high.mode == command_mode) |=> !standby_o)
		else $error("standby entered in command mode");
	win_len_a: assert property (
		(s_ff.st == st_run) && (nxt_s.st == st_done) &&
		(s_ff.high.mode != edge_window_mode) |-> (s_ff.win == win_last))
		else $error("internal window length wrong");
	trunc_a: assert property (
		(s_ff.st == st_run) && (nxt_s.st == st_done) &&
		(s_ff.high.mode != edge_window_mode) && (len == `LEN_MAX_CODE)
		|=> result_o[0] == $past(acc_nxt[0][19:4]))
		else $error("20 bit count not cut to upper 16 bits");
	edge_end_a: assert property (
		(s_ff.st == st_run) && (s_ff.high.mode == edge_window_mode) &&
		sync_fall |=> (s_ff.st == st_done) ##1 !busy_o)
		else $error("edge window did not end on sync edge");
	tm_count_a: assert property (
		(s_ff.st == st_run) && (nxt_s.st == st_done) &&
		s_ff.high.time_measure_enable
		|=> clock_count_o == $past(s_ff.win) + `ACC_W'(1))
		else $error("window clock count wrong");
	ref_top_a: assert property (
		s_ff.low.ref_code[2] |-> (ref_level_o == `REF_TOP))
		else $error("1xx reference code not the largest level");
	ch_off_a: assert property (
		standby_o |-> (ch_enable_o == '0) && $stable(s_ff.acc))
		else $error("channels active in standby");

	continuous_mode_run_c: cover property (
		(s_ff.high.mode == continuous_mode) && (s_ff.st == st_done));
	cmd_run_c: cover property (
		(s_ff.high.mode == command_mode) && (s_ff.st == st_done));
	window_run_c: cover property (
		(s_ff.high.mode == edge_window_mode) && (s_ff.st == st_done));
endmodule

// *** tb/host_model.sv ***
`timescale 1ns/1ps
// Host side of the register port: one strobe per write, reads wait three edges.
module host_model
	import adc_pkg::*;
(
	input wire logic clk_i,
	input wire logic [7:0] rd_data_i,
	output adc_pkg::reg_req_s reg_o
);
	initial reg_o = '0;
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_i);
		reg_o <= '{en: 1'b1, addr: a, data: v};
		@(posedge clk_i);
		reg_o.en <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_i);
		reg_o.addr <= a;
		repeat (3) @(posedge clk_i);
		v = rd_data_i;
	endtask
endmodule

// *** tb/test_adc_standby_and_count_config.sv ***
`timescale 1ns/1ps
module test_adc_standby_and_count_config;
	import adc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic syn_n_i = 1'b1;
	logic [3:0] mod_pulse_i = 4'h0;
	reg_req_s reg_i;
	logic [7:0] rd_data_o;
	logic busy_o;
	logic standby_o;
	logic [3:0] ch_enable_o;
	logic [2:0] ref_level_o;
	res_arr_t result_o;
	logic [19:0] clock_count_o;
	int error_cnt = 0;
	int compares = 0;
	int cycles = 0;
	int seed = 32'hb352;
	logic [7:0] d;
	time t0;
	time t1;
	host_model host (.clk_i(clk_i), .rd_data_i(rd_data_o), .reg_o(reg_i));
	adc_standby_and_count_config DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.reg_i(reg_i), .syn_n_i(syn_n_i), .mod_pulse_i(mod_pulse_i),
		.rd_data_o(rd_data_o), .busy_o(busy_o), .standby_o(standby_o),
		.ch_enable_o(ch_enable_o), .ref_level_o(ref_level_o),
		.result_o(result_o), .clock_count_o(clock_count_o));
	initial forever #2 clk_i = ~clk_i;
	task automatic end_sim();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// The whole run needs about 3500 cycles; a hang stops well past that.
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wait_busy(input logic v, input int lim);
		for (int i = 0; i < lim && busy_o !== v; i++)
			@(posedge clk_i);
		#1 chk(busy_o, v);
	endtask
	task automatic fall_syn(output time t);
		@(posedge clk_i);
		syn_n_i <= 1'b0;
		t = $time;
		repeat (4) @(posedge clk_i);
		syn_n_i <= 1'b1;
	endtask
	// Constant pulse pattern per channel: a set channel counts every cycle.
	task automatic conv(input int len);
		logic [3:0] pat;
		int n;
		pat = 4'($random(seed));
		n = 1024 << len;
		host.wr(4'h1, {4'h0, 4'(len)});
		@(posedge clk_i) mod_pulse_i <= pat;
		host.wr(4'h0, 8'h01);
		wait_busy(1'b1, 4);
		chk(standby_o, 1'b0);
		wait_busy(1'b0, n + 8);
		for (int c = 0; c < 4; c++)
			chk(result_o[c], pat[c] ? n : 0);
		chk(clock_count_o, n);
	endtask
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1 chk(busy_o, 1'b0);
		chk(standby_o, 1'b1);
		host.wr(4'h0, 8'h01);
		repeat (3) @(posedge clk_i);
		#1 chk(standby_o, 1'b0);
		chk(ch_enable_o, 4'hF);
		host.wr(4'h0, 8'h00);
		repeat (3) @(posedge clk_i);
		#1 chk(standby_o, 1'b1);
		chk(ch_enable_o, 4'h0);
		for (int r = 0; r < 8; r++)
		begin
			host.wr(4'h1, {1'b1, 3'(r), 4'h3});
			host.rd(4'h1, d);
			chk(d, {1'b0, 3'(r), 4'h3});
			chk(ref_level_o, r > 3 ? 4 : r);
		end
		host.rd(4'hF, d);
		chk(d, 8'h00);
		host.wr(4'h2, 8'h09);
		conv(0);
		conv(1);
		host.wr(4'h2, 8'h0E);
		repeat (3) @(posedge clk_i);
		#1 chk(standby_o, 1'b1);
		@(posedge clk_i) mod_pulse_i <= 4'hF;
		fall_syn(t0);
		wait_busy(1'b1, 8);
		host.rd(4'h2, d);
		chk(d[2], 1'b0);
		chk(standby_o, 1'b0);
		repeat (291) @(posedge clk_i);
		fall_syn(t1);
		wait_busy(1'b0, 16);
		chk(result_o[0], clock_count_o[15:0]);
		chk(result_o[0], 300);
		chk((t1 - t0) / 4, 300);
		chk(clock_count_o > 298 && clock_count_o < 302, 1);
		chk(standby_o, 1'b0);
		end_sim();
	end
endmodule
